// file: rtl/phy_irq_pkg.sv
// constants shared by the interrupt control and status logic
package phy_irq_pkg;

  // ----------------------------------------------------------------
  // register map (index, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h011;
  localparam logic [9:0] IDX_INTERRUPT_STATUS_EVENT_ENABLE = 10'h012;
  localparam logic [9:0] IDX_PHY_CONTROL_TWO = 10'h01C;

  // ----------------------------------------------------------------
  // interrupt control fields
  // ----------------------------------------------------------------
  localparam int CTRL_W = 4;
  localparam int CTRL_MAP_SEL_BIT = 3;
  localparam int CTRL_TEST_BIT = 2;
  localparam int CTRL_EVENT_INTERRUPT_ENABLE_BIT = 1;
  localparam int CTRL_OE_BIT = 0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

  // ----------------------------------------------------------------
  // status and event enable fields
  // ----------------------------------------------------------------
  localparam int EV_W = 8;
  localparam int STATUS_LSB = 8;
  localparam int EV_LINK_QUALITY = 7;
  localparam int EV_ENERGY_DETECT = 6;
  localparam int EV_LINK_CHANGE = 5;
  localparam int EV_SPEED = 4;
  localparam int EV_DUPLEX_OR_SYNC = 3;
  localparam int EV_AUTONEG_DONE = 2;
  localparam int EV_COUNTER_A = 1;
  localparam int EV_COUNTER_B = 0;
  localparam logic [EV_W-1:0] EV_RESET = 8'h00;

  // ----------------------------------------------------------------
  // phy control two: counter interrupt mode field
  // ----------------------------------------------------------------
  localparam int CNT_MODE_LSB = 7;
  localparam int CNT_MODE_W = 2;
  localparam logic [CNT_MODE_W-1:0] CNT_MODE_RESET = 2'h0;
  localparam logic [CNT_MODE_W-1:0] CNT_MODE_SPLIT = 2'h0;

  // ----------------------------------------------------------------
  // bus data
  // ----------------------------------------------------------------
  localparam int REG_W = 16;
  localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;

endpackage

// file: rtl/event_status_latch.sv
// sticky event status bits, cleared by a mask, set wins over clear
module event_status_latch
  import phy_irq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // events and clear
  input wire logic [EV_W-1:0] set_in,
  input wire logic [EV_W-1:0] clr_in,
  // state
  output logic [EV_W-1:0] status_reg
);

  logic [EV_W-1:0] status_next;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    status_next = set_in | (status_reg & ~clr_in);
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= EV_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

endmodule

// file: rtl/phy_interrupt_control_status.sv
// interrupt control, event status and interrupt pin logic with apb access
// Notes on behaviour
// - control bits 15:4 ignore writes, read zero
// - map select moves sync to 11, speed/duplex 12
// - test bit forces interrupt while set, only with global enable set
// - global enable gates all event interrupts
// - control bit 0 makes pin interrupt output
// - status bits set even when not enabled
// - irq needs event enable plus global enable; the pin also needs control bit 0
// - bits 15,14,13: quality, energy, link; clear-on-read
// - bit 10 autoneg done, clear-on-read
// - bit 12 speed or speed/duplex, clear-on-read
// - sync bit rearms only after sync status empties
// - bit 9 false carrier, or either counter
// - low byte holds event enables, reset zero
// - bit 8 receive error, or control frame
module phy_interrupt_control_status
  import phy_irq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event sources, one-cycle pulses
  input wire logic link_quality_event,
  input wire logic energy_detect_event,
  input wire logic link_status_change_event,
  input wire logic speed_change_event,
  input wire logic duplex_change_event,
  input wire logic autoneg_done_event,
  input wire logic false_carrier_half_full_event,
  input wire logic rx_error_half_full_event,
  input wire logic control_frame_event,
  // time-sync status not empty, level
  input wire logic time_sync_status_pending,
  // shared power-down / interrupt pin
  input wire logic powerdown_or_irq_pin_in,
  output logic powerdown_or_irq_pin_out,
  output logic powerdown_or_irq_pin_oe_n,
  // system side
  output logic powerdown_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] control_reg;
  logic [EV_W-1:0] enable_reg;
  logic [CNT_MODE_W-1:0] cnt_mode_reg;
  logic [EV_W-1:0] status_reg;
  logic [REG_W-1:0] prdata_reg;
  logic ts_armed_reg;
  logic irq_reg;
  logic pin_out_reg;
  logic pin_oe_n_reg;
  logic powerdown_reg;
  logic setup_ph;
  logic access_ph;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_cfg;
  logic mapped;
  logic wr_en;
  logic rd_stat;
  logic map_sel;
  logic test_int;
  logic event_interrupt_enable;
  logic int_oe;
  logic ts_fire;
  logic split_cnt;
  logic event_pend;
  logic irq_next;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    addr_is = (a == {idx, 2'b00});
  endfunction

  function automatic logic [REG_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
                                                input logic [CTRL_W-1:0] ctl,
                                                input logic [EV_W-1:0] sts,
                                                input logic [EV_W-1:0] en,
                                                input logic [CNT_MODE_W-1:0] md);
    logic [REG_W-1:0] v;
    v = REG_ZERO;
    if (addr_is(a, IDX_INTERRUPT_CONTROL)) begin
      v[CTRL_W-1:0] = ctl;
    end else if (addr_is(a, IDX_INTERRUPT_STATUS_EVENT_ENABLE)) begin
      v = {sts, en};
    end else if (addr_is(a, IDX_PHY_CONTROL_TWO)) begin
      v[CNT_MODE_LSB +: CNT_MODE_W] = md;
    end
    read_mux = v;
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign sel_ctrl = addr_is(paddr, IDX_INTERRUPT_CONTROL);
  assign sel_stat = addr_is(paddr, IDX_INTERRUPT_STATUS_EVENT_ENABLE);
  assign sel_cfg = addr_is(paddr, IDX_PHY_CONTROL_TWO);
  assign mapped = sel_ctrl | sel_stat | sel_cfg;
  assign wr_en = access_ph & pwrite & mapped;
  assign rd_stat = access_ph & ~pwrite & sel_stat;
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata = {16'h0000, prdata_reg};

  assign map_sel = control_reg[CTRL_MAP_SEL_BIT];
  assign test_int = control_reg[CTRL_TEST_BIT];
  assign event_interrupt_enable = control_reg[CTRL_EVENT_INTERRUPT_ENABLE_BIT];
  assign int_oe = control_reg[CTRL_OE_BIT];
  assign split_cnt = (cnt_mode_reg == CNT_MODE_SPLIT);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= CTRL_RESET;
    end else if (wr_en && sel_ctrl && pstrb[0]) begin
      control_reg <= pwdata[CTRL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // event enables, status half is read only
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= EV_RESET;
    end else if (wr_en && sel_stat && pstrb[0]) begin
      enable_reg <= pwdata[EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // counter interrupt mode field, crosses byte lanes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_mode_reg <= CNT_MODE_RESET;
    end else if (wr_en && sel_cfg) begin
      if (pstrb[0]) begin
        cnt_mode_reg[0] <= pwdata[CNT_MODE_LSB];
      end
      if (pstrb[1]) begin
        cnt_mode_reg[1] <= pwdata[CNT_MODE_LSB+1];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data captured in setup; clear uses the captured bits
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= REG_ZERO;
    end else if (setup_ph && !pwrite) begin
      prdata_reg <= read_mux(paddr, control_reg, status_reg, enable_reg, cnt_mode_reg);
    end
  end

  assign ev_clr = rd_stat ? prdata_reg[REG_W-1:STATUS_LSB] : EV_RESET;

  // ----------------------------------------------------------------
  // time-sync arming
  // ----------------------------------------------------------------
  assign ts_fire = map_sel & ts_armed_reg & time_sync_status_pending;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_armed_reg <= 1'b1;
    end else if (!time_sync_status_pending) begin
      ts_armed_reg <= 1'b1;
    end else if (ts_fire) begin
      ts_armed_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // event routing
  // ----------------------------------------------------------------
  always_comb begin
    ev_set = EV_RESET;
    ev_set[EV_LINK_QUALITY] = link_quality_event;
    ev_set[EV_ENERGY_DETECT] = energy_detect_event;
    ev_set[EV_LINK_CHANGE] = link_status_change_event;
    ev_set[EV_AUTONEG_DONE] = autoneg_done_event;
    if (map_sel) begin
      ev_set[EV_SPEED] = speed_change_event | duplex_change_event;
      ev_set[EV_DUPLEX_OR_SYNC] = ts_fire;
    end else begin
      ev_set[EV_SPEED] = speed_change_event;
      ev_set[EV_DUPLEX_OR_SYNC] = duplex_change_event;
    end
    if (split_cnt) begin
      ev_set[EV_COUNTER_A] = false_carrier_half_full_event;
      ev_set[EV_COUNTER_B] = rx_error_half_full_event;
    end else begin
      ev_set[EV_COUNTER_A] = false_carrier_half_full_event | rx_error_half_full_event;
      ev_set[EV_COUNTER_B] = control_frame_event;
    end
  end

  event_status_latch u_status (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(ev_set),
    .clr_in(ev_clr),
    .status_reg(status_reg)
  );

  // ----------------------------------------------------------------
  // interrupt and pin
  // ----------------------------------------------------------------
  assign event_pend = |(status_reg & enable_reg);
  assign irq_next = event_interrupt_enable & (event_pend | test_int);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 1'b1;
      pin_oe_n_reg <= 1'b1;
    end else begin
      pin_out_reg <= ~(int_oe & irq_next);
      pin_oe_n_reg <= ~int_oe;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerdown_reg <= 1'b0;
    end else begin
      powerdown_reg <= ~int_oe & ~powerdown_or_irq_pin_in;
    end
  end

  assign irq = irq_reg;
  assign powerdown_or_irq_pin_out = pin_out_reg;
  assign powerdown_or_irq_pin_oe_n = pin_oe_n_reg;
  assign powerdown_req = powerdown_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence ctrl_read_s;
    setup_ph && !pwrite && sel_ctrl ##1 access_ph;
  endsequence

  sequence status_read_s;
    rd_stat && (ev_set == EV_RESET);
  endsequence

  reserved_reads_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_read_s |-> prdata[31:CTRL_W] == '0)
    else $error("reserved control bits read nonzero");

  sync_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (map_sel && ts_fire) |=> status_reg[EV_DUPLEX_OR_SYNC])
    else $error("time-sync event not latched in bit 11");

  duplex_merge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (map_sel && duplex_change_event) |=> status_reg[EV_SPEED])
    else $error("duplex change not merged into bit 12");

  test_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    (test_int && event_interrupt_enable && int_oe) [*2] |=> !powerdown_or_irq_pin_out)
    else $error("test interrupt not driven on pin");

  event_interrupt_enable_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !event_interrupt_enable |=> !irq)
    else $error("interrupt raised with global enable clear");

  pin_role_a: assert property (@(posedge pclk) disable iff (!presetn)
    !int_oe |=> powerdown_or_irq_pin_oe_n && powerdown_or_irq_pin_out)
    else $error("pin driven while configured as input");

  sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    link_status_change_event |=> status_reg[EV_LINK_CHANGE])
    else $error("status bit missed its event");

  irq_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    (event_interrupt_enable && int_oe && (status_reg & enable_reg) != EV_RESET)
    |=> irq && !powerdown_or_irq_pin_out)
    else $error("enabled pending event gave no interrupt");

  read_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_read_s |=> (status_reg & $past(prdata_reg[REG_W-1:STATUS_LSB])) == EV_RESET)
    else $error("status bits not cleared by read");

  sync_rearm_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ts_fire ##1 time_sync_status_pending) |-> !ts_fire)
    else $error("time-sync interrupt rearmed while status pending");

  counter_split_a: assert property (@(posedge pclk) disable iff (!presetn)
    (split_cnt && rx_error_half_full_event) |=> status_reg[EV_COUNTER_B])
    else $error("receive error half-full not latched");

  counter_merge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!split_cnt && rx_error_half_full_event) |=> status_reg[EV_COUNTER_A])
    else $error("combined counter event not latched");

  enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel_stat && pstrb[0]) |=> enable_reg == $past(pwdata[EV_W-1:0]))
    else $error("event enable write lost");

  autoneg_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    autoneg_done_event |=> status_reg[EV_AUTONEG_DONE])
    else $error("autoneg done not latched");

  pin_follows_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    int_oe |=> powerdown_or_irq_pin_out == !irq)
    else $error("pin level disagrees with interrupt");

  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel_ctrl && pstrb[0]) |=> control_reg == $past(pwdata[CTRL_W-1:0]))
    else $error("control write lost");

  powerdown_in_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!int_oe && !powerdown_or_irq_pin_in) |=> powerdown_req)
    else $error("power-down input not passed on");

endmodule

// file: verif/irq_host_model.sv
// host processor model at the shared power-down / interrupt pin
module irq_host_model (
  // pin side
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // host command: pull the pin low as a power-down request
  input wire logic powerdown_low,
  // resolved pin level
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // pull-up when nobody drives the pin
  assign pin_level = !pin_oe_n ? pin_out : !powerdown_low;
endmodule

// file: verif/phy_interrupt_control_status_tb.sv
// self-checking bench for the interrupt control and status block
module phy_interrupt_control_status_tb import phy_irq_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [3:0] ev; logic map; logic [1:0] mode; logic [15:0] exp;} row_t;
  localparam logic [11:0] A_CTL = {IDX_INTERRUPT_CONTROL, 2'b00};
  localparam logic [11:0] A_STS = {IDX_INTERRUPT_STATUS_EVENT_ENABLE, 2'b00};
  localparam logic [11:0] A_PC2 = {IDX_PHY_CONTROL_TWO, 2'b00};
  localparam logic [11:0] A_BAD = 12'h04C;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ts_pend, pd_low;
  logic pin_level, pin_out, pin_oe_n, powerdown_req, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [8:0] ev;
  int n_errors, comparisons;
  row_t rows [13];
  // ----------------------------------------------------------------
  // design and host
  // ----------------------------------------------------------------
  phy_interrupt_control_status i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_quality_event(ev[0]),
    .energy_detect_event(ev[1]), .link_status_change_event(ev[2]),
    .speed_change_event(ev[3]), .duplex_change_event(ev[4]), .autoneg_done_event(ev[5]),
    .false_carrier_half_full_event(ev[6]), .rx_error_half_full_event(ev[7]),
    .control_frame_event(ev[8]), .time_sync_status_pending(ts_pend),
    .powerdown_or_irq_pin_in(pin_level), .powerdown_or_irq_pin_out(pin_out),
    .powerdown_or_irq_pin_oe_n(pin_oe_n), .powerdown_req(powerdown_req), .irq(irq));
  irq_host_model i_host (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .powerdown_low(pd_low),
    .pin_level(pin_level));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task tally_and_finish;
    if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 64);
    if (pready !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task pulse(input logic [3:0] k);
    ev <= 9'h001 << k;
    @(posedge pclk);
    ev <= 9'h000;
    repeat (3) @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{4'd0, 1'b0, 2'd0, 16'h8000}, '{4'd1, 1'b0, 2'd0, 16'h4000},
      '{4'd2, 1'b0, 2'd0, 16'h2000}, '{4'd3, 1'b0, 2'd0, 16'h1000},
      '{4'd4, 1'b0, 2'd0, 16'h0800}, '{4'd3, 1'b1, 2'd0, 16'h1000},
      '{4'd4, 1'b1, 2'd0, 16'h1000}, '{4'd5, 1'b0, 2'd0, 16'h0400},
      '{4'd6, 1'b0, 2'd0, 16'h0200}, '{4'd7, 1'b0, 2'd0, 16'h0100},
      '{4'd7, 1'b0, 2'd2, 16'h0200}, '{4'd6, 1'b0, 2'd1, 16'h0200},
      '{4'd8, 1'b0, 2'd3, 16'h0100}};
    n_errors = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    ev = 9'h000;
    ts_pend = 1'b0;
    pd_low = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_CTL, 32'h0);
    chk_word(q, 32'h0);
    apb(1'b0, A_STS, 32'h0);
    chk_word(q, 32'h0);
    chk_bit(pin_oe_n, 1'b1);
    foreach (rows[r]) begin
      apb(1'b1, A_CTL, {28'h0, rows[r].map, 3'b000});
      apb(1'b1, A_PC2, {23'h0, rows[r].mode, 7'h00});
      pulse(rows[r].ev);
      apb(1'b0, A_STS, 32'h0);
      chk_word(q, {16'h0, rows[r].exp});
      apb(1'b0, A_STS, 32'h0);
      chk_word(q, 32'h0);
    end
    apb(1'b1, A_CTL, 32'hFFFF_FFF0);
    pstrb <= 4'hE;
    apb(1'b1, A_CTL, 32'h0000_000F);
    pstrb <= 4'hF;
    apb(1'b0, A_CTL, 32'h0);
    chk_word(q, 32'h0);
    apb(1'b1, A_STS, 32'h0000_FFFF);
    apb(1'b0, A_STS, 32'h0);
    chk_word(q, 32'h0000_00FF);
    apb(1'b1, A_STS, 32'h80);
    apb(1'b1, A_CTL, 32'h3);
    pulse(4'd1);
    chk_bit(irq, 1'b0);
    apb(1'b0, A_STS, 32'h0);
    chk_word(q, 32'h4080);
    pulse(4'd0);
    chk_bit(irq, 1'b1);
    chk_bit(pin_oe_n, 1'b0);
    chk_bit(pin_level, 1'b0);
    apb(1'b0, A_STS, 32'h0);
    repeat (2) @(posedge pclk);
    chk_bit(pin_level, 1'b1);
    apb(1'b1, A_CTL, 32'h1);
    pulse(4'd0);
    chk_bit(irq, 1'b0);
    chk_bit(pin_level, 1'b1);
    apb(1'b0, A_STS, 32'h0);
    chk_word(q, 32'h8080);
    apb(1'b1, A_CTL, 32'h2);
    pulse(4'd0);
    chk_bit(irq, 1'b1);
    chk_bit(pin_oe_n, 1'b1);
    pd_low <= 1'b1;
    repeat (3) @(posedge pclk);
    chk_bit(powerdown_req, 1'b1);
    pd_low <= 1'b0;
    apb(1'b0, A_STS, 32'h0);
    apb(1'b1, A_CTL, 32'h7);
    repeat (2) @(posedge pclk);
    chk_bit(pin_level, 1'b0);
    apb(1'b1, A_CTL, 32'h3);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b0);
    apb(1'b1, A_CTL, 32'h8);
    ts_pend <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, A_STS, 32'h0);
    chk_word(q, 32'h0880);
    apb(1'b0, A_STS, 32'h0);
    chk_word(q, 32'h0080);
    ts_pend <= 1'b0;
    repeat (2) @(posedge pclk);
    ts_pend <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, A_STS, 32'h0);
    chk_word(q, 32'h0880);
    apb(1'b1, A_BAD, 32'hFFFF);
    chk_bit(e, 1'b1);
    apb(1'b0, A_BAD, 32'h0);
    chk_word(q, 32'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_STS, 32'h0);
    chk_word(q, 32'h0);
    tally_and_finish();
  end
endmodule
